// ### rtl/tlsfp_framer.sv
// Functional notes
// R1 - Whole port runs on the core clock
// R2 - One active-low stream reset for all lanes
// R3 - Lane n payload sits in its 32-bit slice
// R4 - Each lane word goes out LSB byte first
// R5 - Ready high whenever a word is taken
// R6 - Source gives a new word each ready cycle
// R7 - Frame marks describe the next cycle's word
// R8 - Marks 0001/0010 give first-byte position
// R9 - Marks 0100/1000 give first-byte position
// R10 - Short frames set several marks at once
// R11 - Multiframe marks: same coding and timing
// R12 - Marks apply alike to every lane slice
// R13 - Far end holds sync low until aligned
// R14 - System reference comes from outside, synchronous; the framer has no system reference input
`timescale 1ns/1ps
module tlsfp_framer
	import tlsfp_pkg::*;
#(
	parameter int LANES = 2,
	parameter int F_OCTETS = 8,
	parameter int K_FRAMES = 4
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// User payload side
	input wire logic [LANES*LANE_W-1:0] tx_payload,
	output logic payload_ready,
	output logic [WORD_OCTETS-1:0] frame_begin_marks,
	output logic [WORD_OCTETS-1:0] multiframe_begin_marks,
	output logic stream_reset_n,
	// Link side
	input wire logic sync_request_n,
	output logic [LANES*LANE_W-1:0] lane_data,
	output logic [LANES*WORD_OCTETS-1:0] lane_is_k
);
	localparam int MF_OCTETS = F_OCTETS * K_FRAMES;
	localparam int MF_W = $clog2(MF_OCTETS + 1);
	localparam logic [MF_W-1:0] MF_LAST = MF_W'(MF_OCTETS - 1);
	localparam logic [MF_W-1:0] WORD_STEP = MF_W'(WORD_OCTETS);
	localparam logic [2:0] ILA_LAST_MF = 3'(ILA_MULTIFRAMES - 1);

	// One alignment word; byte i is octet (oct + i) of multiframe mf
	function automatic logic [LANE_W+WORD_OCTETS-1:0] ila_word(input logic [MF_W-1:0] oct,
		input logic [2:0] mf);
		logic [LANE_W-1:0] d;
		logic [WORD_OCTETS-1:0] k;
		logic [MF_W-1:0] o;
		d = '0;
		k = '0;
		for (int i = 0; i < WORD_OCTETS; i++) begin
			o = oct + MF_W'(i);
			if (o == '0) begin
				d[i*OCTET_W +: OCTET_W] = CHAR_LANE_START;
				k[i] = 1'b1;
			end else if (o == MF_LAST) begin
				d[i*OCTET_W +: OCTET_W] = CHAR_ALIGN;
				k[i] = 1'b1;
			end else if (mf == CFG_MULTIFRAME && o == MF_W'(1)) begin
				d[i*OCTET_W +: OCTET_W] = CHAR_CFG_START;
				k[i] = 1'b1;
			end else begin
				d[i*OCTET_W +: OCTET_W] = OCTET_W'(o);
			end
		end
		return {k, d};
	endfunction : ila_word

	tlsfp_state_e state_reg;
	tlsfp_state_e state_next;
	logic [MF_W-1:0] ila_oct_reg;
	logic [MF_W-1:0] ila_oct_next;
	logic [2:0] ila_mf_reg;
	logic [2:0] ila_mf_next;
	logic ready_reg;
	logic ready_next;
	logic stream_reset_n_reg;
	logic stream_reset_n_next;
	logic [LANES*LANE_W-1:0] lane_data_reg;
	logic [LANES*LANE_W-1:0] lane_data_next;
	logic [LANES*WORD_OCTETS-1:0] lane_k_reg;
	logic [LANES*WORD_OCTETS-1:0] lane_k_next;
	logic [LANE_W+WORD_OCTETS-1:0] ila_now;
	logic ila_mf_end;

	// Link sequencing
	always_comb begin
		state_next = state_reg;
		ila_oct_next = ila_oct_reg;
		ila_mf_next = ila_mf_reg;
		case (state_reg)
			TLSFP_CGS: begin
				// Counters park at zero so every alignment run starts on octet 0
				ila_oct_next = '0;
				ila_mf_next = '0;
				if (sync_request_n) begin // R13
					state_next = TLSFP_ILA;
				end
			end
			TLSFP_ILA: begin
				if (!sync_request_n) begin
					state_next = TLSFP_CGS;
				end else if (ila_mf_end) begin
					ila_oct_next = '0;
					ila_mf_next = ila_mf_reg + 3'h1;
					if (ila_mf_reg == ILA_LAST_MF) begin
						state_next = TLSFP_DATA;
					end
				end else begin
					ila_oct_next = ila_oct_reg + WORD_STEP;
				end
			end
			TLSFP_DATA: begin
				// Losing sync falls back to commas; the word taken on that edge still goes out
				if (!sync_request_n) begin
					state_next = TLSFP_CGS;
				end
			end
			default: begin
				state_next = TLSFP_CGS;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= TLSFP_CGS;
			ila_oct_reg <= '0;
			ila_mf_reg <= '0;
		end else begin
			state_reg <= state_next;
			ila_oct_reg <= ila_oct_next;
			ila_mf_reg <= ila_mf_next;
		end
	end

	// Ready is registered, so it must look one state ahead to match acceptance
	always_comb begin
		ready_next = (state_next == TLSFP_DATA); // R5
		// User side is held in reset while the link has no alignment
		stream_reset_n_next = (state_next != TLSFP_CGS); // R2
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ready_reg <= READY_RST;
			stream_reset_n_reg <= STREAM_RESET_N_RST;
		end else begin
			ready_reg <= ready_next; // R1
			stream_reset_n_reg <= stream_reset_n_next;
		end
	end

	// Lane words; octet 0 of each slice is the first on the wire
	assign ila_now = ila_word(ila_oct_reg, ila_mf_reg);
	// Last alignment word of a multiframe; F*K must be a multiple of four
	assign ila_mf_end = (ila_oct_reg + WORD_STEP > MF_LAST);

	always_comb begin
		lane_data_next = '0;
		lane_k_next = '0;
		for (int n = 0; n < LANES; n++) begin
			case (state_reg)
				TLSFP_DATA: begin
					// No valid input: every ready cycle carries a fresh word
					lane_data_next[n*LANE_W +: LANE_W] = tx_payload[n*LANE_W +: LANE_W]; // R3 R6
					lane_k_next[n*WORD_OCTETS +: WORD_OCTETS] = '0;
				end
				TLSFP_ILA: begin
					lane_data_next[n*LANE_W +: LANE_W] = ila_now[LANE_W-1:0]; // R4
					lane_k_next[n*WORD_OCTETS +: WORD_OCTETS] =
						ila_now[LANE_W+WORD_OCTETS-1:LANE_W];
				end
				default: begin
					lane_data_next[n*LANE_W +: LANE_W] = {WORD_OCTETS{CHAR_COMMA}};
					lane_k_next[n*WORD_OCTETS +: WORD_OCTETS] = '1;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			lane_data_reg <= '0;
			lane_k_reg <= '0;
		end else begin
			lane_data_reg <= lane_data_next; // R4
			lane_k_reg <= lane_k_next;
		end
	end

	// Both counters restart together, so multiframe marks always sit on frame marks
	// Marks restart whenever no word follows, so the first word after a gap is octet 0
	tlsfp_marks #(
		.LEN(F_OCTETS),
		.LEN_W(MF_W)
	) u_frame_marks (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.restart(!ready_next), // R7
		.advance(ready_next),
		.marks(frame_begin_marks) // R12
	);

	tlsfp_marks #(
		.LEN(MF_OCTETS),
		.LEN_W(MF_W)
	) u_multiframe_marks (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.restart(!ready_next), // R11
		.advance(ready_next),
		.marks(multiframe_begin_marks)
	);

	assign payload_ready = ready_reg;
	assign stream_reset_n = stream_reset_n_reg;
	assign lane_data = lane_data_reg;
	assign lane_is_k = lane_k_reg;
endmodule : tlsfp_framer

// ### rtl/tlsfp_pkg.sv
package tlsfp_pkg;
	// Octets carried per lane word; marker width follows from it
	localparam int WORD_OCTETS = 4;
	localparam int OCTET_W = 8;
	localparam int LANE_W = WORD_OCTETS * OCTET_W;
	// Alignment sequence length in multiframes, and where the config start sits
	localparam int ILA_MULTIFRAMES = 4;
	localparam logic [2:0] CFG_MULTIFRAME = 3'h1;
	// Control characters placed on the lanes
	localparam logic [7:0] CHAR_COMMA = 8'hBC;
	localparam logic [7:0] CHAR_LANE_START = 8'h1C;
	localparam logic [7:0] CHAR_ALIGN = 8'h7C;
	localparam logic [7:0] CHAR_CFG_START = 8'h9C;
	// Reset values of the user-facing outputs
	localparam logic STREAM_RESET_N_RST = 1'b0;
	localparam logic READY_RST = 1'b0;

	typedef enum logic [1:0] {
		TLSFP_CGS = 2'b00,
		TLSFP_ILA = 2'b01,
		TLSFP_DATA = 2'b11
	} tlsfp_state_e;
endpackage : tlsfp_pkg

// ### rtl/tlsfp_marks.sv
`timescale 1ns/1ps
module tlsfp_marks
	import tlsfp_pkg::*;
#(
	parameter int LEN = 8,
	parameter int LEN_W = 12
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// Control
	input wire logic restart,
	input wire logic advance,
	// Byte-position marks of the word after the current one
	output logic [WORD_OCTETS-1:0] marks
);
	localparam logic [LEN_W-1:0] LEN_VAL = LEN_W'(LEN);

	// Walks one word of octets; returns {position after word, start marks}
	function automatic logic [LEN_W+WORD_OCTETS-1:0] scan(input logic [LEN_W-1:0] p_in);
		logic [LEN_W-1:0] p;
		logic [WORD_OCTETS-1:0] m;
		p = p_in;
		m = '0;
		for (int i = 0; i < WORD_OCTETS; i++) begin
			m[i] = (p == '0); // R8 R9 R10
			if (p == LEN_VAL - 1'b1) begin
				p = '0;
			end else begin
				p = p + 1'b1;
			end
		end
		return {p, m};
	endfunction : scan

	localparam logic [LEN_W+WORD_OCTETS-1:0] INIT_SCAN = scan('0);
	localparam logic [WORD_OCTETS-1:0] INIT_MARKS = INIT_SCAN[WORD_OCTETS-1:0];

	logic [LEN_W+WORD_OCTETS-1:0] step_scan;
	logic [LEN_W+WORD_OCTETS-1:0] next_scan;
	logic [LEN_W-1:0] pos_reg;
	logic [LEN_W-1:0] pos_next;
	logic [WORD_OCTETS-1:0] marks_reg;
	logic [WORD_OCTETS-1:0] marks_next;

	always_comb begin
		step_scan = scan(pos_reg);
		next_scan = scan(step_scan[LEN_W+WORD_OCTETS-1:WORD_OCTETS]);
		pos_next = pos_reg;
		marks_next = marks_reg;
		if (restart) begin
			pos_next = '0;
			marks_next = INIT_MARKS;
		end else if (advance) begin
			pos_next = step_scan[LEN_W+WORD_OCTETS-1:WORD_OCTETS];
			marks_next = next_scan[WORD_OCTETS-1:0]; // R7
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			pos_reg <= '0;
			marks_reg <= INIT_MARKS;
		end else begin
			pos_reg <= pos_next;
			marks_reg <= marks_next;
		end
	end

	assign marks = marks_reg;
endmodule : tlsfp_marks

// ### dv/tlsfp_framer_asserts.sv
`timescale 1ns/1ps
module tlsfp_chk
	import tlsfp_pkg::*;
#(
	parameter int LANES = 2,
	parameter int F_OCTETS = 8,
	parameter int K_FRAMES = 4
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// Observed ports
	input wire logic [LANES*LANE_W-1:0] tx_payload,
	input wire logic payload_ready,
	input wire logic [WORD_OCTETS-1:0] frame_begin_marks,
	input wire logic [WORD_OCTETS-1:0] multiframe_begin_marks,
	input wire logic stream_reset_n,
	input wire logic sync_request_n,
	input wire logic [LANES*LANE_W-1:0] lane_data,
	input wire logic [LANES*WORD_OCTETS-1:0] lane_is_k
);
	localparam int MF_WORDS = F_OCTETS * K_FRAMES / WORD_OCTETS;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	a_word_passes: assert property (payload_ready |=>
		lane_data == $past(tx_payload) && lane_is_k == '0) else $error("word not forwarded");
	a_drop_stops: assert property (payload_ready && !sync_request_n |=>
		!payload_ready && !stream_reset_n) else $error("ready kept after sync drop");
	a_ready_held: assert property (payload_ready && sync_request_n |=> payload_ready)
		else $error("ready fell while linked");
	a_ready_rst: assert property (payload_ready |-> stream_reset_n)
		else $error("ready while stream reset");
	a_frame_period: assert property (payload_ready && $past(payload_ready, F_OCTETS) |->
		frame_begin_marks == $past(frame_begin_marks, F_OCTETS)) else $error("frame marks drift");
	a_mf_period: assert property (payload_ready && $past(payload_ready, MF_WORDS) |->
		multiframe_begin_marks == $past(multiframe_begin_marks, MF_WORDS))
		else $error("multiframe marks drift");
	a_mf_in_frame: assert property ((multiframe_begin_marks & ~frame_begin_marks) == '0)
		else $error("multiframe mark off frame");
	a_first_octet: assert property ($rose(payload_ready) |->
		($past(frame_begin_marks) & $past(multiframe_begin_marks) & 4'h1) != '0)
		else $error("first word not at octet 0");
	a_comma_idle: assert property (!stream_reset_n && !sync_request_n |=>
		lane_is_k == '1 && lane_data == {LANES*WORD_OCTETS{CHAR_COMMA}})
		else $error("no comma while idle");
	c_link_up: cover property ($rose(payload_ready));
	c_link_drop: cover property ($fell(payload_ready));
	c_two_marks: cover property (payload_ready && frame_begin_marks == 4'h9);
endmodule : tlsfp_chk

bind tlsfp_framer tlsfp_chk #(.LANES(LANES), .F_OCTETS(F_OCTETS), .K_FRAMES(K_FRAMES))
	tlsfp_chk_inst (.ref_clk(ref_clk), .reset_n(reset_n), .tx_payload(tx_payload),
	.payload_ready(payload_ready), .frame_begin_marks(frame_begin_marks),
	.multiframe_begin_marks(multiframe_begin_marks), .stream_reset_n(stream_reset_n),
	.sync_request_n(sync_request_n), .lane_data(lane_data), .lane_is_k(lane_is_k));

// ### dv/tlsfp_src.sv
`timescale 1ns/1ps
module tlsfp_src
	import tlsfp_pkg::*;
#(
	parameter int LANES = 2
) (
	// Clock and handshake; no system reference, every change rides ref_clk
	input wire logic ref_clk,
	input wire logic payload_ready,
	// Payload toward the framer
	output logic [LANES*LANE_W-1:0] tx_payload
);
	logic [15:0] word_count = 16'h0;
	// No valid line exists, so every taken edge must move to a new word
	always @(posedge ref_clk) begin
		if (payload_ready)
			word_count <= word_count + 16'h1;
	end
	always_comb begin
		for (int n = 0; n < LANES; n++)
			tx_payload[n*LANE_W +: LANE_W] = {word_count, 8'(n), 8'hA5 ^ word_count[7:0]};
	end
endmodule : tlsfp_src

// ### dv/testbench.sv
`timescale 1ns/1ps
module testbench;
	import tlsfp_pkg::*;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic sync_request_n = 1'b0;
	logic payload_ready, stream_reset_n;
	logic [63:0] tx_payload, lane_data;
	logic [7:0] lane_is_k;
	logic [3:0] frame_begin_marks, multiframe_begin_marks;
	int err_count = 0;
	int samples_checked = 0;
	logic [3:0] fexp [3] = '{4'h9, 4'h4, 4'h2};
	// Alignment words of one lane for F = 3, K = 4: four multiframes of three words
	localparam int ILA_WORDS = 12;
	logic [31:0] ila_d [3] = '{{8'h03, 8'h02, 8'h01, CHAR_LANE_START}, 32'h07060504,
		{CHAR_ALIGN, 8'h0A, 8'h09, 8'h08}};
	logic [3:0] ila_k [3] = '{4'h1, 4'h0, 4'h8};
	tlsfp_framer #(.LANES(2), .F_OCTETS(3), .K_FRAMES(4)) tlsfp_framer_inst (
		.ref_clk(ref_clk), .reset_n(reset_n), .tx_payload(tx_payload),
		.payload_ready(payload_ready), .frame_begin_marks(frame_begin_marks),
		.multiframe_begin_marks(multiframe_begin_marks), .stream_reset_n(stream_reset_n),
		.sync_request_n(sync_request_n), .lane_data(lane_data), .lane_is_k(lane_is_k));
	tlsfp_src #(.LANES(2)) tlsfp_src_inst (.ref_clk(ref_clk), .payload_ready(payload_ready),
		.tx_payload(tx_payload));
	initial begin
		forever #12.5 ref_clk = ~ref_clk;
	end
	task automatic check(string name, logic [63:0] seen, logic [63:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : finish_test
	task automatic reset_test();
		check("ready", 64'(payload_ready), 64'h0);
		check("stream reset", 64'(stream_reset_n), 64'h0);
		check("reset marks", 64'(frame_begin_marks), 64'h9);
		reset_n = 1'b1;
		@(negedge ref_clk);
		check("comma data", lane_data, {8{CHAR_COMMA}});
		$display("reset test done");
	endtask : reset_test
	task automatic link_test();
		logic [3:0] pf, pm;
		logic [63:0] word;
		logic [31:0] d;
		logic [3:0] k;
		sync_request_n = 1'b1;
		@(negedge ref_clk);
		check("link stream reset", 64'(stream_reset_n), 64'h1);
		for (int w = 0; w < ILA_WORDS; w++) begin
			check("ila ready", 64'(payload_ready), 64'h0);
			pf = frame_begin_marks;
			pm = multiframe_begin_marks;
			d = ila_d[w % 3];
			k = ila_k[w % 3];
			// Second multiframe carries the config start in octet 1
			if (w == 3) begin
				d[15:8] = CHAR_CFG_START;
				k[1] = 1'b1;
			end
			@(negedge ref_clk);
			check("ila data", lane_data, {2{d}});
			check("ila flags", 64'(lane_is_k), 64'({2{k}}));
		end
		check("ready", 64'(payload_ready), 64'h1);
		check("lead marks", 64'(pf), 64'h9);
		check("lead mf marks", 64'(pm), 64'h1);
		for (int i = 1; i < 8; i++) begin
			check("frame marks", 64'(frame_begin_marks), 64'(fexp[i%3]));
			check("mf marks", 64'(multiframe_begin_marks), (i % 3 == 0) ? 64'h1 : 64'h0);
			word = tx_payload;
			@(negedge ref_clk);
			check("lane data", lane_data, word);
			check("control flags", 64'(lane_is_k), 64'h0);
			check("stream reset", 64'(stream_reset_n), 64'h1);
		end
		$display("link test done");
	endtask : link_test
	task automatic drop_test();
		sync_request_n = 1'b0;
		@(negedge ref_clk);
		check("ready", 64'(payload_ready), 64'h0);
		check("stream reset", 64'(stream_reset_n), 64'h0);
		@(negedge ref_clk);
		check("control flags", 64'(lane_is_k), 64'hFF);
		$display("drop test done");
	endtask : drop_test
	initial begin
		repeat (10) @(negedge ref_clk);
		reset_test();
		link_test();
		drop_test();
		link_test();
		finish_test();
	end
	initial begin
		repeat (2000) @(posedge ref_clk);
		err_count++;
		finish_test();
	end
endmodule : testbench
